//--- timer_pkg.sv
package timer_pkg;
   // ---------------------------------------------
   // widths and offsets
   // ---------------------------------------------
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int NUM_CH = 2;
   localparam int PRE_W = 8;
   localparam logic [7:0] AUX_CTRL_OFF = 8'h00;
   localparam logic [7:0] CORE_CTRL_OFF = 8'h04;
   localparam logic [7:0] AUX_COUNT_OFF = 8'h08;
   localparam logic [7:0] CORE_COUNT_OFF = 8'h0C;
   localparam logic [7:0] CAPTURE_RELOAD_REGISTER_OFF = 8'h10;
   localparam logic [7:0] CH_BASE_OFF = 8'h14;
   localparam logic [7:0] CH_STRIDE = 8'h08;
   localparam logic [7:0] CH_VALUE_DELTA = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h24;
   // ---------------------------------------------
   // timer control fields
   // ---------------------------------------------
   localparam int CTL_PRE_LSB = 0;
   localparam int CTL_SRC_LSB = 3;
   localparam int CTL_RUN = 5;
   localparam int CTL_DOWN = 6;
   localparam int CTL_EXTDIR = 7;
   localparam int CTL_TGL_OUT = 8;
   localparam int CTL_RELOAD = 9;
   localparam int CTL_CAP_CLR = 8;
   localparam int CTL_CAP_EDGE_LSB = 9;
   localparam int CTL_CAP_SRC_LSB = 11;
   // ---------------------------------------------
   // channel control fields
   // ---------------------------------------------
   localparam int CH_MODE_LSB = 0;
   localparam int CH_EDGE_LSB = 3;
   localparam int CH_TSEL = 5;
   // ---------------------------------------------
   // reset values and rates
   // ---------------------------------------------
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] ALL_ONES = 16'hFFFF;
   localparam logic [PRE_W-1:0] PRE_RESET = 8'h00;
   localparam int MIN_CYCLES_PER_COUNT = 2;
   // ---------------------------------------------
   // pin indices
   // ---------------------------------------------
   localparam int PIN_N = 6;
   localparam int P_CAPTURE_INPUT_PIN = 0;
   localparam int P_AUX_CNT = 1;
   localparam int P_CORE_CNT = 2;
   localparam int P_CORE_DIR = 3;
   localparam int P_OTH_CNT = 4;
   localparam int P_OTH_DIR = 5;

   typedef enum logic [1:0] {SRC_PRESCALER, SRC_EXT_RISE, SRC_EXT_BOTH, SRC_LATCH} clk_src_t;
   typedef enum logic [2:0] {
      CH_OFF, CH_CAPTURE, CH_CMP_TOGGLE, CH_CMP_SET, CH_CMP_CLEAR, CH_CMP_PULSE, CH_CMP_EVENT
   } ch_mode_t;

   // ---------------------------------------------
   // shared arithmetic
   // ---------------------------------------------
   // sel 0 gives one tick per two clocks, each step doubles
   function automatic logic prescale_tick(input logic [PRE_W-1:0] cnt, input logic [2:0] sel);
      logic [PRE_W-1:0] mask;
      mask = 8'h01 << sel;
      mask = (mask << 1) - 8'h01;
      return &(cnt | ~mask);
   endfunction

   // msb flags the wrap past all ones or past zero
   function automatic logic [16:0] count_step(input logic [15:0] v, input logic down);
      if (down)
      begin
         return {v == COUNT_RESET, v - 16'h0001};
      end
      return {v == ALL_ONES, v + 16'h0001};
   endfunction
endpackage

//--- cc_link_if.sv
interface cc_link_if;
   logic [15:0] aux_value;
   logic [15:0] core_value;
   logic aux_upd;
   logic core_upd;
   logic pin_rise;
   logic pin_fall;
   logic ctrl_wr;
   logic value_wr;
   logic [15:0] wdata;
   logic [15:0] ctrl;
   logic [15:0] value;
   logic out_level;
   logic req;
   modport timer_side (
      output aux_value, core_value, aux_upd, core_upd, pin_rise, pin_fall,
      output ctrl_wr, value_wr, wdata,
      input ctrl, value, out_level, req
   );
   modport channel_side (
      input aux_value, core_value, aux_upd, core_upd, pin_rise, pin_fall,
      input ctrl_wr, value_wr, wdata,
      output ctrl, value, out_level, req
   );
endinterface

//--- capture_compare_channel.sv
module capture_compare_channel
   import timer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   cc_link_if.channel_side link
);
   logic [15:0] ctrl_reg;
   logic [15:0] value_reg;
   logic out_reg;
   logic req_reg;
   ch_mode_t mode;
   logic [1:0] edge_sel;
   logic [15:0] timer_val;
   logic timer_upd;
   logic is_cmp;
   logic cap_evt;
   logic match;

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   always_comb
   begin
      mode = ch_mode_t'(ctrl_reg[CH_MODE_LSB +: 3]);
      edge_sel = ctrl_reg[CH_EDGE_LSB +: 2];
      timer_val = ctrl_reg[CH_TSEL] ? link.core_value : link.aux_value;
      timer_upd = ctrl_reg[CH_TSEL] ? link.core_upd : link.aux_upd;
      is_cmp = (mode == CH_CMP_TOGGLE) || (mode == CH_CMP_SET) || (mode == CH_CMP_CLEAR)
         || (mode == CH_CMP_PULSE) || (mode == CH_CMP_EVENT);
      cap_evt = (mode == CH_CAPTURE)
         && ((edge_sel[0] && link.pin_rise) || (edge_sel[1] && link.pin_fall));
      match = is_cmp && timer_upd && (timer_val == value_reg);
   end

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_reg <= CTRL_RESET;
      end
      else if (link.ctrl_wr)
      begin
         ctrl_reg <= link.wdata;
      end
   end

   // the hardware capture beats a software write in the same cycle
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         value_reg <= COUNT_RESET;
      end
      else if (cap_evt)
      begin
         value_reg <= timer_val;
      end
      else if (link.value_wr)
      begin
         value_reg <= link.wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         req_reg <= 1'b0;
      end
      else
      begin
         req_reg <= cap_evt || match;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         out_reg <= 1'b0;
      end
      else
      begin
         case (mode)
            CH_CMP_TOGGLE: out_reg <= out_reg ^ match;
            CH_CMP_SET: out_reg <= out_reg | match;
            CH_CMP_CLEAR: out_reg <= out_reg & ~match;
            CH_CMP_PULSE: out_reg <= match;
            CH_CMP_EVENT: out_reg <= out_reg;
            default: out_reg <= 1'b0;
         endcase
      end
   end

   assign link.ctrl = ctrl_reg;
   assign link.value = value_reg;
   assign link.out_level = out_reg;
   assign link.req = req_reg;
endmodule

//--- dual_timer_capture_reload.sv
module dual_timer_capture_reload
   import timer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic capture_input_pin,
   input wire logic aux_count_pin,
   input wire logic core_count_pin,
   input wire logic core_direction_pin,
   input wire logic other_unit_count_input,
   input wire logic other_unit_direction_input,
   input wire logic [NUM_CH-1:0] cc_pin,
   output logic toggle_latch_output_pin,
   output logic core_overflow_tick,
   output logic capture_event,
   output logic [NUM_CH-1:0] cc_out,
   output logic [NUM_CH-1:0] cc_req
);
   localparam int SYNC_N = PIN_N + NUM_CH;

   logic [SYNC_N-1:0] s1_reg;
   logic [SYNC_N-1:0] s2_reg;
   logic [SYNC_N-1:0] s3_reg;
   logic [SYNC_N-1:0] filt_reg;
   logic [SYNC_N-1:0] filt_next;
   logic [SYNC_N-1:0] rise;
   logic [SYNC_N-1:0] fall;
   logic [SYNC_N-1:0] raw_pins;

   logic [PRE_W-1:0] pre_cnt_reg;
   logic [15:0] aux_ctrl_reg;
   logic [15:0] core_ctrl_reg;
   logic [15:0] aux_count_reg;
   logic [15:0] core_count_reg;
   logic [15:0] capture_reload_register_reg;
   logic latch_reg;
   logic latch_next;
   logic tgl_pin_reg;
   logic core_ovf_reg;
   logic cap_evt_reg;
   logic aux_upd_reg;
   logic core_upd_reg;
   logic [DATA_W-1:0] rdata_reg;

   logic core_tick;
   logic aux_tick;
   logic core_down;
   logic aux_down;
   logic [16:0] core_step;
   logic [16:0] aux_step;
   logic core_wrap;
   logic core_reload;
   logic cap_rise;
   logic cap_fall;
   logic cap_trig;
   logic cap_clear;
   logic [1:0] cap_edge;
   logic [NUM_CH-1:0][15:0] ch_ctrl;
   logic [NUM_CH-1:0][15:0] ch_value;
   logic [15:0] status_word;

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   assign raw_pins = {cc_pin, other_unit_direction_input, other_unit_count_input,
      core_direction_pin, core_count_pin, aux_count_pin, capture_input_pin};

   // a level is taken only once stages two and three agree
   always_comb
   begin
      filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
      rise = filt_next & ~filt_reg;
      fall = ~filt_next & filt_reg;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         filt_reg <= '0;
      end
      else
      begin
         s1_reg <= raw_pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   // ---------------------------------------------
   // prescaler
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pre_cnt_reg <= PRE_RESET;
      end
      else
      begin
         pre_cnt_reg <= pre_cnt_reg + 8'h01;
      end
   end

   // ---------------------------------------------
   // count enables and direction
   // ---------------------------------------------
   always_comb
   begin
      case (clk_src_t'(core_ctrl_reg[CTL_SRC_LSB +: 2]))
         SRC_PRESCALER: core_tick = prescale_tick(pre_cnt_reg, core_ctrl_reg[CTL_PRE_LSB +: 3]);
         SRC_EXT_RISE: core_tick = rise[P_CORE_CNT];
         SRC_EXT_BOTH: core_tick = rise[P_CORE_CNT] | fall[P_CORE_CNT];
         default: core_tick = 1'b0;
      endcase
      core_tick = core_tick & core_ctrl_reg[CTL_RUN];
      core_down = core_ctrl_reg[CTL_EXTDIR] ? filt_reg[P_CORE_DIR] : core_ctrl_reg[CTL_DOWN];
      core_step = count_step(core_count_reg, core_down);
      core_wrap = core_tick & core_step[16];
      core_reload = core_wrap & core_ctrl_reg[CTL_RELOAD];
      latch_next = latch_reg ^ core_wrap;
   end

   always_comb
   begin
      case (clk_src_t'(aux_ctrl_reg[CTL_SRC_LSB +: 2]))
         SRC_PRESCALER: aux_tick = prescale_tick(pre_cnt_reg, aux_ctrl_reg[CTL_PRE_LSB +: 3]);
         SRC_EXT_RISE: aux_tick = rise[P_AUX_CNT];
         SRC_EXT_BOTH: aux_tick = rise[P_AUX_CNT] | fall[P_AUX_CNT];
         SRC_LATCH: aux_tick = core_wrap;
         default: aux_tick = 1'b0;
      endcase
      aux_tick = aux_tick & aux_ctrl_reg[CTL_RUN];
      // no direction pin exists, the extdir bit is ignored here
      aux_down = aux_ctrl_reg[CTL_DOWN];
      aux_step = count_step(aux_count_reg, aux_down);
   end

   // ---------------------------------------------
   // capture trigger for the reload register
   // ---------------------------------------------
   always_comb
   begin
      cap_edge = aux_ctrl_reg[CTL_CAP_EDGE_LSB +: 2];
      case (aux_ctrl_reg[CTL_CAP_SRC_LSB +: 2])
         2'h1:
         begin
            cap_rise = rise[P_OTH_CNT];
            cap_fall = fall[P_OTH_CNT];
         end
         2'h2:
         begin
            cap_rise = rise[P_OTH_DIR];
            cap_fall = fall[P_OTH_DIR];
         end
         2'h3:
         begin
            cap_rise = rise[P_OTH_CNT] | rise[P_OTH_DIR];
            cap_fall = fall[P_OTH_CNT] | fall[P_OTH_DIR];
         end
         default:
         begin
            cap_rise = rise[P_CAPTURE_INPUT_PIN];
            cap_fall = fall[P_CAPTURE_INPUT_PIN];
         end
      endcase
      cap_trig = (cap_edge[0] & cap_rise) | (cap_edge[1] & cap_fall);
      cap_clear = cap_trig & aux_ctrl_reg[CTL_CAP_CLR];
   end

   // ---------------------------------------------
   // control registers
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aux_ctrl_reg <= CTRL_RESET;
         core_ctrl_reg <= CTRL_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == AUX_CTRL_OFF)
         begin
            aux_ctrl_reg <= reg_wdata;
         end
         if (reg_addr == CORE_CTRL_OFF)
         begin
            core_ctrl_reg <= reg_wdata;
         end
      end
   end

   // ---------------------------------------------
   // timers; hardware events beat software writes
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         core_count_reg <= COUNT_RESET;
      end
      else if (core_reload)
      begin
         core_count_reg <= capture_reload_register_reg;
      end
      else if (core_tick)
      begin
         core_count_reg <= core_step[15:0];
      end
      else if (reg_wr && reg_addr == CORE_COUNT_OFF)
      begin
         core_count_reg <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aux_count_reg <= COUNT_RESET;
      end
      else if (cap_clear)
      begin
         aux_count_reg <= COUNT_RESET;
      end
      else if (aux_tick)
      begin
         aux_count_reg <= aux_step[15:0];
      end
      else if (reg_wr && reg_addr == AUX_COUNT_OFF)
      begin
         aux_count_reg <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         capture_reload_register_reg <= COUNT_RESET;
      end
      else if (cap_trig)
      begin
         capture_reload_register_reg <= aux_count_reg;
      end
      else if (reg_wr && reg_addr == CAPTURE_RELOAD_REGISTER_OFF)
      begin
         capture_reload_register_reg <= reg_wdata;
      end
   end

   // ---------------------------------------------
   // toggle latch and event outputs
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         latch_reg <= 1'b0;
         tgl_pin_reg <= 1'b0;
         core_ovf_reg <= 1'b0;
         cap_evt_reg <= 1'b0;
         aux_upd_reg <= 1'b0;
         core_upd_reg <= 1'b0;
      end
      else
      begin
         latch_reg <= latch_next;
         tgl_pin_reg <= latch_next & core_ctrl_reg[CTL_TGL_OUT];
         core_ovf_reg <= core_wrap;
         cap_evt_reg <= cap_trig;
         aux_upd_reg <= cap_clear | aux_tick;
         core_upd_reg <= core_tick;
      end
   end

   // ---------------------------------------------
   // capture/compare channels
   // ---------------------------------------------
   for (genvar i = 0; i < NUM_CH; i++)
   begin : g_ch
      localparam logic [7:0] CTRL_A = 8'(CH_BASE_OFF + 8'(i) * CH_STRIDE);
      cc_link_if link ();
      assign link.aux_value = aux_count_reg;
      assign link.core_value = core_count_reg;
      assign link.aux_upd = aux_upd_reg;
      assign link.core_upd = core_upd_reg;
      assign link.pin_rise = rise[PIN_N + i];
      assign link.pin_fall = fall[PIN_N + i];
      assign link.ctrl_wr = reg_wr && (reg_addr == CTRL_A);
      assign link.value_wr = reg_wr && (reg_addr == 8'(CTRL_A + CH_VALUE_DELTA));
      assign link.wdata = reg_wdata;
      assign ch_ctrl[i] = link.ctrl;
      assign ch_value[i] = link.value;
      assign cc_out[i] = link.out_level;
      assign cc_req[i] = link.req;
      capture_compare_channel u_ch (
         .sys_clk(sys_clk),
         .reset_n(reset_n),
         .link(link.channel_side)
      );
   end

   // ---------------------------------------------
   // read port; unmapped addresses read zero
   // ---------------------------------------------
   assign status_word = {13'h0000, core_down, aux_down, latch_reg};

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_reg <= '0;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            AUX_CTRL_OFF: rdata_reg <= aux_ctrl_reg;
            CORE_CTRL_OFF: rdata_reg <= core_ctrl_reg;
            AUX_COUNT_OFF: rdata_reg <= aux_count_reg;
            CORE_COUNT_OFF: rdata_reg <= core_count_reg;
            CAPTURE_RELOAD_REGISTER_OFF: rdata_reg <= capture_reload_register_reg;
            8'h14: rdata_reg <= ch_ctrl[0];
            8'h18: rdata_reg <= ch_value[0];
            8'h1C: rdata_reg <= ch_ctrl[1];
            8'h20: rdata_reg <= ch_value[1];
            STATUS_OFF: rdata_reg <= status_word;
            default: rdata_reg <= '0;
         endcase
      end
      else
      begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata = rdata_reg;
   assign toggle_latch_output_pin = tgl_pin_reg;
   assign core_overflow_tick = core_ovf_reg;
   assign capture_event = cap_evt_reg;
endmodule

//--- dual_timer_capture_reload_chk.sv
module dual_timer_capture_reload_chk
   import timer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic capture_input_pin,
   input wire logic other_unit_count_input,
   input wire logic other_unit_direction_input,
   input wire logic toggle_latch_output_pin,
   input wire logic core_overflow_tick,
   input wire logic capture_event,
   input wire logic [NUM_CH-1:0] cc_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // shadow state
   // ----------------------------------------
   logic run_reg;
   logic tgl_reg;
   logic [2:0] pin_reg;
   logic [7:0] since_reg;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         run_reg <= 1'b0;
         tgl_reg <= 1'b0;
      end
      else if (reg_wr && reg_addr == CORE_CTRL_OFF)
      begin
         run_reg <= reg_wdata[CTL_RUN];
         tgl_reg <= reg_wdata[CTL_TGL_OUT];
      end
   end
   // saturating age of the last capture-source pin change
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_reg <= 3'h0;
         since_reg <= 8'hFF;
      end
      else
      begin
         pin_reg <= {capture_input_pin, other_unit_count_input, other_unit_direction_input};
         if (pin_reg != {capture_input_pin, other_unit_count_input, other_unit_direction_input})
            since_reg <= 8'h00;
         else if (since_reg != 8'hFF)
            since_reg <= since_reg + 8'h01;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_tick_spacing: assert property (core_overflow_tick |=> !core_overflow_tick)
      else $error("core wraps closer than two clocks");
   a_capture_single: assert property (capture_event |=> !capture_event)
      else $error("capture pulse longer than one cycle");
   a_match_single: assert property (cc_req[1] |=> !cc_req[1])
      else $error("channel request longer than one cycle");
   a_pin_gated: assert property (!tgl_reg && !$past(tgl_reg) |-> !toggle_latch_output_pin)
      else $error("toggle pin high while disabled");
   a_pin_on_wrap: assert property ($changed(toggle_latch_output_pin) && tgl_reg && $past(tgl_reg)
      && $past(tgl_reg, 2) |-> core_overflow_tick)
      else $error("toggle pin changed without a core wrap");
   a_tick_needs_run: assert property (!run_reg && !$past(run_reg) && !$past(run_reg, 2)
      |-> !core_overflow_tick)
      else $error("core wrapped while stopped");
   a_capture_cause: assert property (capture_event |-> since_reg < 8'h0C)
      else $error("capture without a recent pin change");
endmodule

//--- pin_partner.sv
module pin_partner
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] want,
   output logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // pin levels
   // ----------------------------------------
   // levels move one clock after a request; pins are held, never glitch
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         pins <= 8'h00;
      else
         pins <= want;
   end
endmodule

//--- dual_timer_capture_reload_bench.sv
module dual_timer_capture_reload_bench
   import timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // signals and tasks
   // ----------------------------------------
   logic sys_clk;
   logic reset_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic [7:0] want;
   logic [7:0] pins;
   logic toggle_latch_output_pin;
   logic core_overflow_tick;
   logic capture_event;
   logic [NUM_CH-1:0] cc_out;
   logic [NUM_CH-1:0] cc_req;
   logic [3:0] flags;
   logic [15:0] d;
   logic [15:0] v;
   logic e;
   int fails;
   int checks;
   int ticks;
   int caps;
   int reqs;
   int cyc;
   assign flags = {cc_req, capture_event, core_overflow_tick};
   pin_partner pp (.sys_clk(sys_clk), .reset_n(reset_n), .want(want), .pins(pins));
   dual_timer_capture_reload dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .capture_input_pin(pins[0]), .aux_count_pin(pins[1]), .core_count_pin(pins[2]),
      .core_direction_pin(pins[3]), .other_unit_count_input(pins[4]),
      .other_unit_direction_input(pins[5]), .cc_pin(pins[7:6]),
      .toggle_latch_output_pin(toggle_latch_output_pin), .core_overflow_tick(core_overflow_tick),
      .capture_event(capture_event), .cc_out(cc_out), .cc_req(cc_req));
   always @(posedge sys_clk)
   begin
      if (core_overflow_tick === 1'b1)
         ticks++;
      if (capture_event === 1'b1)
         caps++;
      if (cc_req[0] === 1'b1)
         reqs++;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] x);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= x;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] x);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 x = reg_rdata;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      checks++;
      if (((got >= lo) && (got <= hi)) !== 1'b1)
      begin
         fails++;
         $display("[ERR] t=%0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic wait_bit(input int i, input int lim, output int n);
      n = 1;
      @(posedge sys_clk);
      #1;
      while (flags[i] !== 1'b1 && n < lim)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask
   task automatic setp(input logic [7:0] m);
      @(posedge sys_clk);
      want <= m;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic pulse(input logic [7:0] m);
      @(posedge sys_clk);
      want <= want | m;
      repeat (12) @(posedge sys_clk);
      want <= want & ~m;
      repeat (12) @(posedge sys_clk);
   endtask
   // stop first so a tick cannot beat the count write
   task automatic core_go(input logic [15:0] c, input logic [15:0] x);
      wr(CORE_CTRL_OFF, 16'h0000);
      wr(CORE_COUNT_OFF, c);
      wr(CORE_CTRL_OFF, x);
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial
   begin
      #(20000 * 50);
      fails++;
      conclude();
   end
   initial
   begin
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      want = 8'h00;
      void'($urandom(72505));
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int a = 0; a <= 'h30; a += 4)
      begin
         rd(8'(a), d);
         chk(d, 16'h0000, 16'h0000);
      end
      v = 16'($urandom);
      wr(8'h30, v);
      wr(STATUS_OFF, v);
      wr(AUX_COUNT_OFF, v);
      rd(8'h30, d);
      chk(d, 16'h0000, 16'h0000);
      rd(STATUS_OFF, d);
      chk(d, 16'h0000, 16'h0000);
      rd(AUX_COUNT_OFF, d);
      chk(d, v, v);
      $display("test registers done");
      setp(8'h08);
      wr(CORE_CTRL_OFF, 16'h0080);
      wr(AUX_CTRL_OFF, 16'h0040);
      rd(STATUS_OFF, d);
      chk(d, 16'h0006, 16'h0006);
      wr(AUX_CTRL_OFF, 16'h0000);
      rd(STATUS_OFF, d);
      chk(d, 16'h0004, 16'h0004);
      setp(8'h00);
      rd(STATUS_OFF, d);
      chk(d, 16'h0000, 16'h0000);
      $display("test direction done");
      core_go(16'hFFF0, 16'h0020);
      wait_bit(0, 60, cyc);
      chk(16'(cyc), 16'h001E, 16'h0024);
      rd(CORE_COUNT_OFF, d);
      chk(d, 16'h0000, 16'h0004);
      rd(STATUS_OFF, d);
      chk(d, 16'h0001, 16'h0001);
      core_go(16'h0003, 16'h0060);
      wait_bit(0, 30, cyc);
      chk(16'(cyc), 16'h0006, 16'h000A);
      rd(STATUS_OFF, d);
      chk(d, 16'h0004, 16'h0004);
      core_go(16'h0000, 16'h0028);
      v = 16'(1 + $urandom % 5);
      repeat (v) pulse(8'h04);
      rd(CORE_COUNT_OFF, d);
      chk(d, v, v);
      $display("test core timer done");
      wr(CAPTURE_RELOAD_REGISTER_OFF, 16'hFFF0);
      wr(AUX_COUNT_OFF, 16'h0000);
      wr(AUX_CTRL_OFF, 16'h0038);
      ticks = 0;
      core_go(16'hFFF0, 16'h0320);
      repeat (200) @(posedge sys_clk);
      wr(CORE_CTRL_OFF, 16'h0300);
      rd(AUX_COUNT_OFF, d);
      chk(d, 16'(ticks), 16'(ticks));
      chk(16'(ticks), 16'h0005, 16'h0007);
      rd(CORE_COUNT_OFF, d);
      chk(d, 16'hFFF0, 16'hFFFF);
      rd(STATUS_OFF, d);
      chk(d, 16'(ticks % 2), 16'(ticks % 2));
      chk(16'(toggle_latch_output_pin), 16'(ticks % 2), 16'(ticks % 2));
      wr(CORE_CTRL_OFF, 16'h0000);
      $display("test reload chain done");
      for (int s = 0; s < 3; s++)
         for (int g = 1; g < 4; g++)
         begin
            wr(AUX_CTRL_OFF, 16'(16'h0120 | (g << 9) | (s << 11)));
            wr(CH_BASE_OFF, 16'(1 | (g << 3)));
            caps = 0;
            reqs = 0;
            pulse(s == 0 ? 8'h41 : (s == 1 ? 8'h50 : 8'h60));
            chk(16'(caps), 16'((g & 1) + (g >> 1)), 16'((g & 1) + (g >> 1)));
            chk(16'(reqs), 16'((g & 1) + (g >> 1)), 16'((g & 1) + (g >> 1)));
            rd(CAPTURE_RELOAD_REGISTER_OFF, d);
            chk(d, 16'h0001, 16'hFFFF);
            rd(AUX_COUNT_OFF, d);
            chk(d, 16'h0000, 16'h0020);
            rd(CH_BASE_OFF + CH_VALUE_DELTA, d);
            chk(d, 16'h0001, 16'hFFFF);
         end
      $display("test capture done");
      wr(CH_BASE_OFF, 16'h0000);
      v = 16'h0100 + 16'($urandom % 16'h1000);
      wr(CH_BASE_OFF + CH_STRIDE + CH_VALUE_DELTA, v);
      e = 1'b0;
      for (int m = 2; m < 7; m++)
      begin
         wr(AUX_CTRL_OFF, 16'h0000);
         wr(AUX_COUNT_OFF, v - 16'h0008);
         wr(CH_BASE_OFF + CH_STRIDE, 16'(m));
         wr(AUX_CTRL_OFF, 16'h0020);
         wait_bit(3, 40, cyc);
         e = (m == 2) ? ~e : ((m == 3 || m == 5) ? 1'b1 : ((m == 4) ? 1'b0 : e));
         chk(16'(cyc), 16'h000E, 16'h0014);
         chk(16'(cc_out), 16'({e, 1'b0}), 16'({e, 1'b0}));
         if (m == 5)
            e = 1'b0;
         @(posedge sys_clk);
         #1;
         chk(16'(cc_out), 16'({e, 1'b0}), 16'({e, 1'b0}));
      end
      $display("test compare done");
      conclude();
   end
endmodule

bind dual_timer_capture_reload dual_timer_capture_reload_chk chk_i (.sys_clk(sys_clk),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_input_pin(capture_input_pin),
   .other_unit_count_input(other_unit_count_input),
   .other_unit_direction_input(other_unit_direction_input),
   .toggle_latch_output_pin(toggle_latch_output_pin), .core_overflow_tick(core_overflow_tick),
   .capture_event(capture_event), .cc_req(cc_req));
